// [rtl/bfr_pkg.sv]
// Purpose: shared constants and types for the bridge fault reporting block
// Assumes: 20 MHz system clock
// Notes: timing counts are derived from the printed times and the clock rate
package bfr_pkg;
    localparam int CLK_HZ = 20000000;
    // bridge pwm period: 20 us plus code times 1.6 us, kept in ns
    localparam int PERIOD_BASE_NS = 20000;
    localparam int PERIOD_STEP_NS = 1600;
    localparam int PERIOD_BASE_CYC = PERIOD_BASE_NS / 50;
    localparam int PERIOD_STEP_CYC = PERIOD_STEP_NS / 50;
    // blanking step of 400 ns per code unit
    localparam int BLANK_STEP_NS = 400;
    localparam int BLANK_STEP_CYC = BLANK_STEP_NS / 50;
    localparam int DIAG_COMMON_BIT = 15;
    localparam int SER_BITS = 16;
    localparam logic [1:0] BURST_TWO = 2'h2;
    localparam logic [1:0] BURST_THREE = 2'h3;
    localparam logic [2:0] BURST_FOUR = 3'h4;

    typedef enum logic [1:0] {
        BFR_MODE_DIRECT = 2'h0,
        BFR_MODE_INDIRECT = 2'h1,
        BFR_MODE_SPEED = 2'h2,
        BFR_MODE_CURRENT = 2'h3
    } bfr_mode_e;

    typedef enum logic [3:0] {
        BFR_ST_IDLE = 4'h1,
        BFR_ST_FIRST = 4'h2,
        BFR_ST_LOW = 4'h4,
        BFR_ST_GAP = 4'h8
    } bfr_state_e;

    // raw fault conditions from the detectors
    typedef struct packed {
        logic warn_temp;
        logic over_temp;
        logic lost_sync;
        logic short_fault;
        logic undervolt;
        logic serial_err;
    } bfr_faults_s;
endpackage

// [rtl/bfr_core.sv]
// Purpose: bridge fault response, fault pin reporting and bridge pwm timing
// Assumes: all inputs synchronous to i_clk; detectors deliver level conditions
// Notes: fault pin is open drain, modelled as output value plus enable
module bfr_core
    import bfr_pkg::*;
#(
    parameter int PERIOD_W = 5,
    parameter int BLANK_W = 4,
    parameter int CNT_W = 12
) (
    input wire logic i_clk, // system clock, 20 MHz
    input wire logic i_sys_rst, // power-on reset, async, high
    input wire bfr_mode_e i_mode, // control mode
    input wire logic [PERIOD_W-1:0] i_period_code, // bridge pwm period code
    input wire logic [BLANK_W-1:0] i_blank_code, // blanking code
    input wire logic i_stop_on_fault_enable, // gates off on faults when set
    input wire logic i_pwm_in, // control pwm input level
    input wire logic i_pwm_zero, // pwm input measured at 0% duty
    input wire logic i_drive_start, // bridge enters drive configuration
    input wire logic i_ilim_cmp, // raw current limit comparator
    input wire logic [5:0] i_ds_short, // raw drain-source monitor per transistor
    input wire bfr_faults_s i_faults, // other fault conditions
    input wire logic i_serial_strobe_n, // serial strobe, low during frame
    input wire logic i_serial_clk_rise, // one pulse per serial clock rising edge
    input wire logic i_serial_is_read, // current frame reads diagnostics
    input wire logic [5:0] i_gate_req, // gate drives from commutation
    output logic o_fault_out_n, // fault pin output value (always 0)
    output logic o_fault_oe, // fault pin drive enable, high pulls low
    output logic [5:0] o_gate, // gate drives after fault action
    output logic o_bridge_period_tick, // start of each fixed bridge pwm period
    output logic o_off_time_done, // current limit off-time elapsed
    output logic o_ilim_trip, // blanked current limit trip
    output logic o_blanking, // blanking interval active
    output logic [DIAG_COMMON_BIT:0] o_diag, // latched diagnostic word
    output logic o_diag_first_bit, // first serial bit, the common flag
    output logic o_write_ok // serial write accepted (one cycle)
);
    // diagnostic bit positions of this block
    localparam int D_SERR = 0;
    localparam int D_UV = 1;
    localparam int D_WT = 2;
    localparam int D_OT = 3;
    localparam int D_SYNC = 4;
    localparam int D_SHORT = 5;

    // time in cycles for a period code, also used for the off-time
    function automatic logic [CNT_W-1:0] period_cycles(input logic [PERIOD_W-1:0] code);
        period_cycles = CNT_W'(PERIOD_BASE_CYC + int'(code) * PERIOD_STEP_CYC);
    endfunction

    logic indirect;
    logic fixed_mode;
    assign indirect = (i_mode != BFR_MODE_DIRECT);
    assign fixed_mode = (i_mode == BFR_MODE_INDIRECT) || (i_mode == BFR_MODE_SPEED);

    // fixed bridge pwm period counter
    logic [CNT_W-1:0] per_cnt;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            per_cnt <= '0;
        end else if (per_cnt >= period_cycles(i_period_code) - CNT_W'(1)) begin
            per_cnt <= '0;
        end else begin
            per_cnt <= per_cnt + CNT_W'(1);
        end
    end
    assign o_bridge_period_tick = fixed_mode && (per_cnt == '0);

    // off-time counter starts on a trip only while idle; length is the period in every mode here
    logic [CNT_W-1:0] off_cnt;
    logic off_run;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            off_cnt <= '0;
            off_run <= 1'b0;
        end else if (o_ilim_trip && !off_run) begin
            off_cnt <= period_cycles(i_period_code) - CNT_W'(1);
            off_run <= 1'b1;
        end else if (off_run) begin
            if (off_cnt == '0) begin
                off_run <= 1'b0;
            end else begin
                off_cnt <= off_cnt - CNT_W'(1);
            end
        end
    end
    assign o_off_time_done = off_run && (off_cnt == '0);

    // blanking counter, one step per 400 ns derived from the clock
    logic [BLANK_W+3:0] blank_cnt;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            blank_cnt <= '0;
        end else if (i_drive_start) begin
            blank_cnt <= (BLANK_W+4)'(int'(i_blank_code) * BLANK_STEP_CYC);
        end else if (blank_cnt != '0) begin
            blank_cnt <= blank_cnt - (BLANK_W+4)'(1);
        end
    end
    assign o_blanking = (blank_cnt != '0);
    assign o_ilim_trip = i_ilim_cmp && !o_blanking && !i_drive_start;
    // short monitors share the blanking so edges are not mistaken for shorts
    logic [5:0] ds_valid;
    assign ds_valid = (o_blanking || i_drive_start) ? 6'h00 : i_ds_short;
    logic short_now;
    assign short_now = |ds_valid;

    // pwm period boundaries from rising edges of the control input
    logic pwm_d;
    logic pwm_edge;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pwm_d <= 1'b1; // idle line is pulled high, so no false edge after reset
        end else begin
            pwm_d <= i_pwm_in;
        end
    end
    assign pwm_edge = i_pwm_in && !pwm_d;

    // serial frame checking and diagnostic read reset
    logic [4:0] sclk_cnt;
    logic strobe_d;
    logic frame_end;
    logic frame_good;
    logic diag_clear;
    logic frame_err;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            strobe_d <= 1'b1;
            sclk_cnt <= '0;
        end else begin
            strobe_d <= i_serial_strobe_n;
            if (i_serial_strobe_n) begin
                sclk_cnt <= '0;
            end else if (i_serial_clk_rise && sclk_cnt != 5'h1f) begin
                sclk_cnt <= sclk_cnt + 5'h01;
            end
        end
    end
    assign frame_end = i_serial_strobe_n && !strobe_d;
    assign frame_good = frame_end && (sclk_cnt == 5'(SER_BITS));
    assign frame_err = frame_end && (sclk_cnt != 5'(SER_BITS));
    assign diag_clear = frame_good && i_serial_is_read;
    assign o_write_ok = frame_good && !i_serial_is_read;

    // latched diagnostics; a new fault beats a clear in the same cycle
    logic [5:0] raw_bits;
    logic [5:0] diag_bits;
    assign raw_bits = {short_now, i_faults.lost_sync, i_faults.over_temp, i_faults.warn_temp,
                       i_faults.undervolt, i_faults.serial_err | frame_err};
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            diag_bits <= '0;
        end else if (diag_clear) begin
            diag_bits <= raw_bits;
        end else begin
            diag_bits <= diag_bits | raw_bits;
        end
    end
    always_comb begin
        o_diag = '0;
        o_diag[5:0] = diag_bits;
        o_diag[DIAG_COMMON_BIT] = |diag_bits;
    end
    assign o_diag_first_bit = o_diag[DIAG_COMMON_BIT];

    // short shutdown latch under stop-on-fault
    logic short_latch;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            short_latch <= 1'b0;
        end else if (short_now && i_stop_on_fault_enable) begin
            short_latch <= 1'b1;
        end else if (i_pwm_zero || frame_good) begin
            short_latch <= 1'b0;
        end
    end

    // gate action: all off for undervoltage, lost sync or stop-on-fault faults
    logic all_off;
    logic [5:0] single_off;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            single_off <= '0;
        end else if (i_pwm_zero || frame_good) begin
            single_off <= ds_valid;
        end else begin
            single_off <= single_off | ds_valid;
        end
    end
    assign all_off = i_faults.undervolt
        || (i_stop_on_fault_enable && (short_now || short_latch || i_faults.lost_sync
            || i_faults.over_temp))
        || i_faults.lost_sync;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_gate <= '0;
        end else if (all_off) begin
            o_gate <= '0;
        end else if (!i_stop_on_fault_enable) begin
            o_gate <= i_gate_req & ~single_off;
        end else begin
            o_gate <= i_gate_req;
        end
    end

    // fault pin decision: steady low or burst group and repeat
    logic steady_low;
    logic [2:0] burst_len;
    logic burst_rep;
    logic burst_req;
    always_comb begin
        steady_low = 1'b0;
        burst_len = 3'h0;
        burst_rep = 1'b0;
        if (!indirect) begin
            steady_low = (|raw_bits[5:1]) || short_latch || (|single_off);
        end else begin
            steady_low = i_faults.undervolt
                || (i_stop_on_fault_enable && i_faults.over_temp);
            if (short_now || short_latch || (|single_off)) begin
                burst_len = {1'b0, BURST_TWO};
                burst_rep = i_stop_on_fault_enable;
            end else if (i_faults.lost_sync) begin
                burst_len = {1'b0, BURST_THREE};
                burst_rep = 1'b1;
            end else if (i_faults.over_temp) begin
                burst_len = BURST_FOUR;
                burst_rep = 1'b1;
            end else if (i_faults.warn_temp && i_stop_on_fault_enable) begin
                burst_len = BURST_FOUR;
            end
        end
    end
    assign burst_req = (burst_len != 3'h0) && !steady_low;

    // burst sequencer counted in pwm input periods
    bfr_state_e state;
    logic [2:0] per_left;
    logic [2:0] cur_len;
    logic fired;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= BFR_ST_IDLE;
            per_left <= '0;
            cur_len <= '0;
            fired <= 1'b0;
        end else begin
            unique case (state)
                BFR_ST_IDLE: begin
                    if (!burst_req) begin
                        fired <= 1'b0;
                    end else if (burst_rep || !fired) begin
                        state <= BFR_ST_FIRST;
                        cur_len <= burst_len;
                        fired <= 1'b1;
                    end
                end
                BFR_ST_FIRST: begin
                    if (pwm_edge) begin
                        state <= BFR_ST_LOW;
                        per_left <= cur_len;
                    end
                end
                BFR_ST_LOW: begin
                    if (pwm_edge) begin
                        if (per_left == 3'h1) begin
                            state <= burst_rep ? BFR_ST_GAP : BFR_ST_IDLE;
                            per_left <= cur_len;
                        end else begin
                            per_left <= per_left - 3'h1;
                        end
                    end
                end
                BFR_ST_GAP: begin
                    if (!burst_req) begin
                        state <= BFR_ST_IDLE;
                    end else if (pwm_edge) begin
                        if (per_left == 3'h1) begin
                            // a repeat starts on a period edge, so there is no partial period
                            state <= BFR_ST_LOW;
                            per_left <= burst_len;
                            cur_len <= burst_len;
                        end else begin
                            per_left <= per_left - 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    // pin low only when reported; bursts release it so pwm keeps control
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_fault_oe <= 1'b0;
        end else begin
            o_fault_oe <= steady_low
                || (burst_req && state == BFR_ST_IDLE && (burst_rep || !fired))
                || (state == BFR_ST_FIRST) || (state == BFR_ST_LOW);
        end
    end
    assign o_fault_out_n = 1'b0;
endmodule

// [verif/bfr_pwm_model.sv]
// Purpose: control pwm source on the far side of the fault pin
// Assumes: period of P system clocks, half duty
// Notes: zero duty holds the line low, so no period edges arrive then
module bfr_pwm_model #(
    parameter int P = 40
) (
    input wire logic i_clk, // system clock
    input wire logic i_sys_rst, // reset
    input wire logic i_zero, // controller asks for 0% duty
    output logic o_pwm // control pwm line
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    // free running phase count; edges land on clock edges only
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) cnt <= 0;
        else cnt <= (cnt == P - 1) ? 0 : cnt + 1;
    end
    // the line keeps control even while the device reports faults
    assign o_pwm = !i_zero && (cnt < P / 2);
endmodule

// [verif/bfr_core_properties.sv]
// Purpose: timing checks on the bridge fault reporting ports
// Assumes: one clock domain, reset async high
// Notes: diag clear is allowed only one or two clocks after strobe rises
module bfr_core_properties
    import bfr_pkg::*;
#(
    parameter int BLANK_W = 4
) (
    input wire logic i_clk, // clock
    input wire logic i_sys_rst, // reset
    input wire bfr_mode_e i_mode, // mode
    input wire logic [BLANK_W-1:0] i_blank_code, // blank code
    input wire logic i_stop_on_fault_enable, // stop on fault
    input wire logic i_drive_start, // drive start
    input wire bfr_faults_s i_faults, // faults
    input wire logic i_serial_strobe_n, // strobe
    input wire logic o_fault_out_n, // pin value
    input wire logic o_fault_oe, // pin enable
    input wire logic [5:0] o_gate, // gates
    input wire logic o_ilim_trip, // trip
    input wire logic o_blanking, // blanking
    input wire logic [DIAG_COMMON_BIT:0] o_diag, // diag word
    input wire logic o_diag_first_bit // first bit
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    // blank code 1 gives exactly eight clocks of masking
    sequence blank_run;
        o_blanking [*8] ##1 !o_blanking;
    endsequence
    // a pulse lasts at least two pwm periods, far beyond eight clocks
    sequence fault_burst;
        o_fault_oe [*8];
    endsequence
    fault_pin_low_a: assert property (o_fault_out_n == 1'b0)
        else $error("fault pin value not low");
    uv_gates_off_a: assert property (i_faults.undervolt |=> o_gate == 6'h00)
        else $error("gates on during undervoltage");
    stop_gates_off_a: assert property (i_stop_on_fault_enable
        && (i_faults.over_temp || i_faults.lost_sync) |=> o_gate == 6'h00)
        else $error("gates on after stopping fault");
    direct_low_a: assert property (i_mode == BFR_MODE_DIRECT && (i_faults.over_temp
        || i_faults.lost_sync || i_faults.undervolt || i_faults.warn_temp) |=> o_fault_oe)
        else $error("fault pin released in direct mode");
    common_flag_a: assert property (o_diag_first_bit == o_diag[DIAG_COMMON_BIT]
        && o_diag[DIAG_COMMON_BIT] == (|o_diag[DIAG_COMMON_BIT-1:0]))
        else $error("common flag wrong");
    diag_hold_a: assert property ($fell(o_diag[DIAG_COMMON_BIT]) |->
        ($past(i_serial_strobe_n) && !$past(i_serial_strobe_n, 2))
        || ($past(i_serial_strobe_n, 2) && !$past(i_serial_strobe_n, 3)))
        else $error("diag cleared without a frame");
    blank_len_a: assert property (i_drive_start && i_blank_code == 1 |=> blank_run)
        else $error("blanking length wrong");
    ilim_blank_a: assert property (o_ilim_trip |-> !o_blanking)
        else $error("trip inside blanking");
    pulse_start_a: assert property ($rose(i_faults.lost_sync)
        && i_mode == BFR_MODE_INDIRECT |=> fault_burst)
        else $error("no low pulse at detection");
endmodule
bind bfr_core bfr_core_properties #(.BLANK_W(BLANK_W)) u_props (
    .i_clk, .i_sys_rst, .i_mode, .i_blank_code, .i_stop_on_fault_enable,
    .i_drive_start, .i_faults, .i_serial_strobe_n, .o_fault_out_n, .o_fault_oe,
    .o_gate, .o_ilim_trip, .o_blanking, .o_diag, .o_diag_first_bit
);

// [verif/bfr_core_tb.sv]
// Purpose: directed checks of fault pin, gates, diag word and timing
// Assumes: inputs move 2 ns after each rising clock edge
// Notes: pwm period cut to P clocks so fault bursts stay short
module bfr_core_tb
    import bfr_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int P = 40;
    logic clk = 1'b0, rst = 1'b1, sof = 1'b0, pzero = 1'b0, dstart = 1'b0;
    logic ilim = 1'b0, sstb_n = 1'b1, scl = 1'b0, srd = 1'b0, wseen = 1'b0;
    logic [4:0] pc = 5'h03;
    logic [3:0] bc = 4'h1;
    logic [5:0] ds = 6'h00, greq = 6'h2d, gate;
    bfr_mode_e mode = BFR_MODE_DIRECT;
    bfr_faults_s flt = '0;
    logic pwm, fn, oe, tick, otd, trip, blk, d1, wok;
    logic [15:0] diag;
    int fails = 0, checks = 0, n;
    `define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin fails++; \
        $display("[FAIL] %s exp %0h got %0h", nm, e, a); end end
    bfr_core dut (
        .i_clk(clk), .i_sys_rst(rst), .i_mode(mode), .i_period_code(pc),
        .i_blank_code(bc), .i_stop_on_fault_enable(sof), .i_pwm_in(pwm),
        .i_pwm_zero(pzero), .i_drive_start(dstart), .i_ilim_cmp(ilim),
        .i_ds_short(ds), .i_faults(flt), .i_serial_strobe_n(sstb_n),
        .i_serial_clk_rise(scl), .i_serial_is_read(srd), .i_gate_req(greq),
        .o_fault_out_n(fn), .o_fault_oe(oe), .o_gate(gate), .o_bridge_period_tick(tick),
        .o_off_time_done(otd), .o_ilim_trip(trip), .o_blanking(blk), .o_diag(diag),
        .o_diag_first_bit(d1), .o_write_ok(wok)
    );
    bfr_pwm_model #(.P(P)) far (.i_clk(clk), .i_sys_rst(rst), .i_zero(pzero), .o_pwm(pwm));
    // write accept is a one-cycle pulse, so catch it at every falling edge
    always @(negedge clk) if (wok === 1'b1) wseen <= 1'b1;
    initial forever #25 clk = ~clk;
    // the run needs about 3600 clocks; this leaves wide margin
    initial begin
        #500000;
        fails++;
        stop_test();
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    // frame of k clock pulses; read flag held until well past frame end
    task automatic frame(input int k, input logic rd);
        wseen = 1'b0;
        srd = rd;
        sstb_n = 1'b0;
        cyc(2);
        repeat (k) begin scl = 1'b1; cyc(1); scl = 1'b0; cyc(1); end
        sstb_n = 1'b1;
        cyc(3);
        srd = 1'b0;
        cyc(2);
    endtask
    task automatic span(input logic v);
        n = 0;
        while (oe === v && n < 1000) begin cyc(1); n++; end
    endtask
    // one whole released phase and one whole active phase, k periods each
    task automatic burst(input string nm, input int k);
        n = 0;
        while (oe !== 1'b1 && n < 9) begin cyc(1); n++; end
        span(1'b1);
        span(1'b0);
        `CHK(nm, 1'b1, (n >= k * P - 2) && (n <= k * P + 2))
        span(1'b1);
        `CHK(nm, 1'b1, (n >= k * P - 2) && (n <= k * P + 2))
    endtask
    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #2;
        rst = 1'b0;
        cyc(2);
        `CHK("reset oe", 1'b0, oe)
        `CHK("reset diag", 16'h0000, diag)
        flt.over_temp = 1'b1;
        cyc(2);
        `CHK("direct oe", 1'b1, oe)
        `CHK("run on", greq, gate)
        `CHK("ot bit", 16'h8008, diag)
        flt.over_temp = 1'b0;
        cyc(2);
        `CHK("oe gone", 1'b0, oe)
        `CHK("ot kept", 16'h8008, diag)
        frame(16, 1'b1);
        `CHK("diag read", 16'h0000, diag)
        for (int k = 15; k <= 17; k += 2) begin
            frame(k, 1'b0);
            `CHK("bad frame", 1'b0, wseen)
            `CHK("bad flag", 16'h8001, diag)
        end
        frame(16, 1'b0);
        `CHK("good frame", 1'b1, wseen)
        `CHK("write kept", 16'h8001, diag)
        $display("test direct and serial done");
        mode = BFR_MODE_INDIRECT;
        flt.undervolt = 1'b1;
        cyc(2);
        `CHK("uv gate", 6'h00, gate)
        `CHK("uv oe", 1'b1, oe)
        flt.undervolt = 1'b0;
        cyc(2);
        `CHK("uv gone", greq, gate)
        sof = 1'b1;
        flt.over_temp = 1'b1;
        cyc(5 * P);
        `CHK("ot held", 1'b1, oe)
        `CHK("ot stop", 6'h00, gate)
        flt.over_temp = 1'b0;
        sof = 1'b0;
        cyc(2);
        flt.over_temp = 1'b1;
        burst("ot pulses", 4);
        `CHK("ot run", greq, gate)
        flt.over_temp = 1'b0;
        cyc(10 * P);
        `CHK("ot gone", 1'b0, oe)
        $display("test supply and heat done");
        sof = 1'b1;
        ds = 6'h01;
        cyc(2);
        ds = 6'h00;
        burst("short pulses", 2);
        `CHK("short latch", 6'h00, gate)
        pzero = 1'b1;
        cyc(4);
        pzero = 1'b0;
        cyc(2);
        `CHK("zero duty", greq, gate)
        sof = 1'b0;
        ds = 6'h04;
        cyc(2);
        ds = 6'h00;
        cyc(2);
        `CHK("one gate", greq & 6'h3b, gate)
        frame(16, 1'b0);
        `CHK("frame clears", greq, gate)
        frame(16, 1'b1);
        $display("test short done");
        ilim = 1'b1;
        dstart = 1'b1;
        cyc(1);
        dstart = 1'b0;
        ds = 6'h3f;
        cyc(3);
        ds = 6'h00;
        n = 3;
        while (blk === 1'b1 && n < 40) begin cyc(1); n++; end
        `CHK("blank len", 8, n)
        `CHK("trip after", 1'b1, trip)
        `CHK("ds masked", 16'h0000, diag)
        cyc(1);
        ilim = 1'b0;
        n = 1;
        while (otd !== 1'b1 && n < 600) begin cyc(1); n++; end
        `CHK("off time", 496, n)
        n = 0;
        while (tick !== 1'b1 && n < 600) begin cyc(1); n++; end
        cyc(1);
        n = 1;
        while (tick !== 1'b1 && n < 600) begin cyc(1); n++; end
        `CHK("bridge period", 496, n)
        $display("test timing done");
        sof = 1'b1;
        flt.lost_sync = 1'b1;
        burst("sync pulses", 3);
        `CHK("sync stop", 6'h00, gate)
        $display("test sync done");
        stop_test();
    end
endmodule
